/* File: core/stt_top.sv */
// system tick timer: registers, control, wrap flag and tick event
`timescale 1ns/1ps
`default_nettype none
`include "stt_map.svh"
module stt_top (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic [3:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic dbg_access_i,
  input wire logic debug_master_kind_i,
  input wire logic core_halted_i,
  output logic [31:0] rdata_o,
  output logic tick_pend_o,
  output logic irq_o
);
  import stt_pkg::*;

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    stt_state_t mode;
    logic enable;
    logic tick_irq_enable;
    logic clock_select;
    logic wrap_flag;
    stt_count_t reload;
    logic [31:0] rdata;
    logic tick_pend;
  } stt_st_t;

  stt_st_t st, next_st;
  stt_count_t cnt_value;
  logic cnt_wrap;
  logic cnt_run;
  logic cnt_clear;
  logic stat_rd;
  logic irq_stat;
  logic irq_mask;

  function automatic logic hit(input logic [3:0] a, input logic [3:0] off);
    hit = (a == off);
  endfunction

  // ------------------------------------------------------------
  // counter
  // ------------------------------------------------------------
  // write clears value
  assign cnt_clear = wr_i && hit(addr_i, `STT_OFF_CURRENT);
  assign cnt_run = (st.mode == STT_RUN) && !core_halted_i;

  stt_down_count #(
    .W(`STT_CNT_W)
  ) u_count (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .run_i(cnt_run),
    .clear_i(cnt_clear),
    .reload_i(st.reload),
    .value_o(cnt_value),
    .wrap_o(cnt_wrap)
  );

  assign stat_rd = rd_i && hit(addr_i, `STT_OFF_IRQ_STAT);

  stt_irq u_irq (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .event_i(cnt_wrap),
    .mask_wr_i(wr_i && hit(addr_i, `STT_OFF_IRQ_STAT)),
    .mask_din_i(wdata_i[0]),
    .stat_rd_i(stat_rd),
    .stat_o(irq_stat),
    .mask_o(irq_mask),
    .irq_o(irq_o)
  );

  // ------------------------------------------------------------
  // control and register access
  // ------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.rdata = 32'h0000_0000;
    next_st.tick_pend = 1'b0;
    if (wr_i && hit(addr_i, `STT_OFF_CTRL)) begin
      next_st.enable = wdata_i[`STT_BIT_ENABLE];
      next_st.tick_irq_enable = wdata_i[`STT_BIT_TICK_IRQ_EN];
      next_st.clock_select = wdata_i[`STT_BIT_CLKSEL];
    end
    if (wr_i && hit(addr_i, `STT_OFF_RELOAD)) begin
      next_st.reload = wdata_i[23:0];
    end
    case (st.mode)
      STT_IDLE: begin
        if (st.enable && st.reload != '0) begin
          next_st.mode = STT_RUN;
        end
      end
      STT_RUN: begin
        if (!st.enable) begin
          next_st.mode = STT_IDLE;
        end else if (cnt_run && cnt_value == '0 && st.reload == '0) begin
          // stop when the count is zero with zero reload
          next_st.mode = STT_IDLE;
        end
      end
      default: begin
        next_st.mode = STT_IDLE;
      end
    endcase
    if (rd_i) begin
      if (hit(addr_i, `STT_OFF_CTRL)) begin
        next_st.rdata[`STT_BIT_WRAP] = st.wrap_flag;
        next_st.rdata[`STT_BIT_CLKSEL] = st.clock_select;
        next_st.rdata[`STT_BIT_TICK_IRQ_EN] = st.tick_irq_enable;
        next_st.rdata[`STT_BIT_ENABLE] = st.enable;
        if (!dbg_access_i || !debug_master_kind_i) begin
          next_st.wrap_flag = 1'b0;
        end
      end else if (hit(addr_i, `STT_OFF_RELOAD)) begin
        next_st.rdata[23:0] = st.reload;
      end else if (hit(addr_i, `STT_OFF_CURRENT)) begin
        next_st.rdata[23:0] = cnt_value;
      end else if (hit(addr_i, `STT_OFF_IRQ_STAT)) begin
        next_st.rdata[0] = irq_stat;
        next_st.rdata[8] = irq_mask;
      end
    end
    if (cnt_clear) begin
      next_st.wrap_flag = 1'b0;
    end
    if (cnt_wrap) begin
      next_st.wrap_flag = 1'b1;
      next_st.tick_pend = st.tick_irq_enable;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      st <= '{mode: STT_IDLE, default: '0};
    end else begin
      st <= next_st;
    end
  end

  assign rdata_o = st.rdata;
  assign tick_pend_o = st.tick_pend;

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);

  a_wrap_sets_flag: assert property (
    cnt_wrap |=> st.wrap_flag) else $error("wrap flag not set");
  a_clear_no_pend: assert property (
    cnt_clear |=> !tick_pend_o) else $error("clear raised tick");
  a_clear_zeroes: assert property (
    cnt_clear && !cnt_wrap |=> cnt_value == '0 && !st.wrap_flag)
    else $error("current write did not clear");
  a_halt_holds: assert property (
    core_halted_i && !cnt_clear |=> cnt_value == $past(cnt_value))
    else $error("counter moved in halt");
  a_reload_wrap: assert property (
    cnt_run && !cnt_clear && cnt_value == '0 |=> cnt_value == $past(st.reload))
    else $error("no reload at zero");
  a_pend_enable: assert property (
    cnt_wrap |=> tick_pend_o == $past(st.tick_irq_enable))
    else $error("pend wrong");
  a_read_clears: assert property (
    rd_i && !dbg_access_i && hit(addr_i, `STT_OFF_CTRL) && !cnt_wrap
    |=> !st.wrap_flag) else $error("read did not clear flag");
  a_dbg_keeps: assert property (
    rd_i && dbg_access_i && debug_master_kind_i && st.wrap_flag
    |=> st.wrap_flag) else $error("debug read cleared flag");
  a_current_read: assert property (
    rd_i && hit(addr_i, `STT_OFF_CURRENT)
    |=> rdata_o[23:0] == $past(cnt_value)) else $error("bad current");
  a_disable_stop: assert property (
    !st.enable && st.mode == STT_RUN |=> st.mode == STT_IDLE)
    else $error("did not stop");

  c_wrap: cover property (cnt_wrap);
  c_pend: cover property (tick_pend_o);
  c_zero_stop: cover property (st.mode == STT_RUN ##1 st.mode == STT_IDLE);
endmodule
`default_nettype wire

/* File: core/stt_map.svh */
// register map and field constants of the system tick timer
`ifndef STT_MAP_SVH
`define STT_MAP_SVH

`define STT_ADDR_W 4
`define STT_OFF_CTRL 4'h0
`define STT_OFF_RELOAD 4'h4
`define STT_OFF_CURRENT 4'h8
`define STT_OFF_IRQ_STAT 4'hC
`define STT_OFF_IRQ_MASK 4'h0
`define STT_BIT_ENABLE 0
`define STT_BIT_TICK_IRQ_EN 1
`define STT_BIT_CLKSEL 2
`define STT_BIT_WRAP 16
`define STT_CNT_W 24
`define STT_CTRL_RESET 32'h0000_0000

`endif

/* File: core/stt_pkg.sv */
// types of the system tick timer
package stt_pkg;
  typedef enum logic [1:0] {
    STT_IDLE = 2'b01,
    STT_RUN = 2'b10
  } stt_state_t;

  typedef logic [23:0] stt_count_t;
endpackage

/* File: core/stt_down_count.sv */
// 24-bit down counter with reload and clear
`timescale 1ns/1ps
`default_nettype none
module stt_down_count #(
  parameter int W = 24
) (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic run_i,
  input wire logic clear_i,
  input wire logic [W-1:0] reload_i,
  output logic [W-1:0] value_o,
  output logic wrap_o
);
  typedef struct packed {
    logic [W-1:0] value;
  } stt_cnt_st_t;

  stt_cnt_st_t st, next_st;

  always_comb begin
    next_st = st;
    if (clear_i) begin
      next_st.value = '0;
    end else if (run_i) begin
      if (st.value == '0) begin
        next_st.value = reload_i;
      end else begin
        next_st.value = st.value - 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign value_o = st.value;
  // step from one to zero
  assign wrap_o = run_i && !clear_i && (st.value == W'(1));
endmodule
`default_nettype wire

/* File: core/stt_irq.sv */
// sticky interrupt status with mask and read clear
`timescale 1ns/1ps
`default_nettype none
module stt_irq (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic event_i,
  input wire logic mask_wr_i,
  input wire logic mask_din_i,
  input wire logic stat_rd_i,
  output logic stat_o,
  output logic mask_o,
  output logic irq_o
);
  typedef struct packed {
    logic stat;
    logic mask;
  } stt_irq_st_t;

  stt_irq_st_t st, next_st;

  always_comb begin
    next_st = st;
    if (mask_wr_i) begin
      next_st.mask = mask_din_i;
    end
    if (stat_rd_i) begin
      next_st.stat = 1'b0;
    end
    if (event_i) begin
      next_st.stat = 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign stat_o = st.stat;
  assign mask_o = st.mask;
  assign irq_o = st.stat & st.mask;
endmodule
`default_nettype wire

/* File: sim/system_tick_down_counter_test.sv */
// self-checking bench of the system tick timer
`timescale 1ns/1ps
`default_nettype none
`include "stt_map.svh"
module system_tick_down_counter_test;
  logic sys_clk_i, rst_n_i, wr_i, rd_i, dbg_access_i;
  logic debug_master_kind_i, core_halted_i, tick_pend_o, irq_o;
  logic [3:0] addr_i;
  logic [31:0] wdata_i, rdata_o, rv;
  int n_mismatch = 0;
  int checked = 0;
  int n, k;
  stt_top uut (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .dbg_access_i(dbg_access_i),
    .debug_master_kind_i(debug_master_kind_i),
    .core_halted_i(core_halted_i), .rdata_o(rdata_o),
    .tick_pend_o(tick_pend_o), .irq_o(irq_o));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  initial begin
    sys_clk_i = 1'b0;
    forever #2.5 sys_clk_i = ~sys_clk_i;
  end
  function automatic int period(input int r);
    return r + 1;
  endfunction
  task automatic chk(input logic [31:0] got, exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge sys_clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic dbg);
    @(posedge sys_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    dbg_access_i <= dbg;
    @(posedge sys_clk_i);
    rd_i <= 1'b0;
    dbg_access_i <= 1'b0;
    #1 rv = rdata_o;
  endtask
  task automatic wait_tick(output int c);
    c = 0;
    do begin
      @(posedge sys_clk_i);
      #1 c++;
    end while (tick_pend_o !== 1'b1 && c < 3000);
  endtask
  task automatic end_of_test();
    $display("mismatches %0d checks %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    #(5 * 50000);
    n_mismatch++;
    end_of_test();
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {rst_n_i, wr_i, rd_i, dbg_access_i} = 4'h0;
    {debug_master_kind_i, core_halted_i} = 2'h0;
    addr_i = 4'h0;
    wdata_i = 32'h0;
    void'($urandom(32'h55C3));
    repeat (3) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    rd(`STT_OFF_CTRL, 1'b0);
    chk(rv, `STT_CTRL_RESET);
    rd(`STT_OFF_CURRENT, 1'b0);
    chk(rv, 32'h0);
    rd(4'h2, 1'b0);
    chk(rv, 32'h0);
    n = 20 + $urandom % 10;
    wr(`STT_OFF_RELOAD, {8'hFF, n[23:0]});
    rd(`STT_OFF_RELOAD, 1'b0);
    chk(rv, 32'(n));
    wr(`STT_OFF_CTRL, 32'h7);
    rd(`STT_OFF_CTRL, 1'b0);
    chk(rv, 32'h7);
    wait_tick(k);
    wait_tick(k);
    chk(32'(k), 32'(period(n)));
    rd(`STT_OFF_CTRL, 1'b0);
    chk(32'(rv[16]), 32'h1);
    rd(`STT_OFF_CTRL, 1'b0);
    chk(32'(rv[16]), 32'h0);
    for (int m = 1; m >= 0; m--) begin
      wait_tick(k);
      debug_master_kind_i <= m[0];
      rd(`STT_OFF_CTRL, 1'b1);
      chk(32'(rv[16]), 32'h1);
      rd(`STT_OFF_CTRL, 1'b0);
      chk(32'(rv[16]), 32'(m));
    end
    wait_tick(k);
    @(posedge sys_clk_i);
    addr_i <= `STT_OFF_CURRENT;
    rd_i <= 1'b1;
    @(posedge sys_clk_i);
    #1 rv = rdata_o;
    @(posedge sys_clk_i);
    rd_i <= 1'b0;
    #1 chk(rdata_o, rv - 32'h1);
    core_halted_i <= 1'b1;
    rd(`STT_OFF_CURRENT, 1'b0);
    k = int'(rv);
    repeat (5) @(posedge sys_clk_i);
    rd(`STT_OFF_CURRENT, 1'b0);
    chk(rv, 32'(k));
    core_halted_i <= 1'b0;
    wait_tick(k);
    @(posedge sys_clk_i);
    addr_i <= `STT_OFF_CURRENT;
    wdata_i <= $urandom;
    wr_i <= 1'b1;
    repeat (3) begin
      @(posedge sys_clk_i);
      wr_i <= 1'b0;
      #1 chk(32'(tick_pend_o), 32'h0);
    end
    rd(`STT_OFF_CTRL, 1'b0);
    chk(32'(rv[16]), 32'h0);
    wr(`STT_OFF_CTRL, 32'h5);
    rd(`STT_OFF_IRQ_STAT, 1'b0);
    repeat (2 * n + 4) begin
      @(posedge sys_clk_i);
      #1 chk({tick_pend_o, irq_o}, 32'h0);
    end
    core_halted_i <= 1'b1;
    wr(`STT_OFF_IRQ_STAT, 32'h1);
    #1 chk(32'(irq_o), 32'h1);
    rd(`STT_OFF_IRQ_STAT, 1'b0);
    chk(rv, 32'h101);
    chk(32'(irq_o), 32'h0);
    rd(`STT_OFF_CTRL, 1'b0);
    chk(32'(rv[16]), 32'h1);
    core_halted_i <= 1'b0;
    wr(`STT_OFF_CTRL, 32'h7);
    wr(`STT_OFF_RELOAD, 32'h0);
    wait_tick(k);
    chk(32'(k <= period(n)), 32'h1);
    repeat (3 * n) begin
      @(posedge sys_clk_i);
      #1 chk(32'(tick_pend_o), 32'h0);
    end
    rd(`STT_OFF_CURRENT, 1'b0);
    chk(rv, 32'h0);
    end_of_test();
  end
endmodule
`default_nettype wire
